// ### spe_defines.svh
// Operation
// - Sample serial input on rising clock, modes 00/11.
// - Shift serial output on falling clock edge.
// - Chip select high floats output, device idles.
// - First byte is opcode; ignore undefined values.
// - Opcodes 06 set, 04 clear latch, 05 status.
// - Opcodes 01 status write, 03 read, 02 write.
// - Status bits: pin enable, zeros, guards, latch, busy.
// - Busy reads one during write; not writable.
// - Set command sets latch; clear command clears.
// - Guard bits nonvolatile, written by status write.
// - Guard code selects none, quarter, half, all.
// - Pin low plus enable blocks status writes.
// - Latch zero refuses writes; guards still apply.
// - Reset leaves write latch cleared.
// - Latch set only on select rise after byte.
// - Write has 16-bit address; upper bits ignored.
// - Programming starts at select rise ending write.
// - While busy only status read is served.
// - Page load up to 32 bytes, wraps in-page.
// - Finished write cycle clears the write latch.
// - Status write changes only bits 2, 3, 7.
// - Read increments address, wraps, runs until select rises.
// - Paused: output floats, serial input ignored.
// - Undefined opcode: output floats until frame end.
`ifndef SPE_DEFINES_SVH
`define SPE_DEFINES_SVH

// Opcodes.
`define SPE_OP_SET_LATCH 8'h06
`define SPE_OP_CLR_LATCH 8'h04
`define SPE_OP_RD_SR 8'h05
`define SPE_OP_WR_SR 8'h01
`define SPE_OP_READ 8'h03
`define SPE_OP_WRITE 8'h02

// Status register bit positions.
`define SPE_SR_GUARD_PIN_EN 7
`define SPE_SR_BP_HI 3
`define SPE_SR_BP_LO 2
`define SPE_SR_LATCH 1
`define SPE_SR_BUSY 0

// Reset value of the nonvolatile status bits.
`define SPE_NV_RESET 8'h00

// Array and page geometry.
`define SPE_ADDR_W 11
`define SPE_PAGE_BYTES 32
`define SPE_PAGE_AW 5

// Self-timed write cycle, in ns, and the system clock rate.
`define SPE_TWC_NS 5000000
`define SPE_CLK_MHZ 250
`define SPE_TWC_CYCLES ((`SPE_TWC_NS * `SPE_CLK_MHZ) / 1000)

`endif

// ### spe_pkg.sv
package spe_pkg;

  // Internal programming sequencer states.
  typedef enum logic [1:0] {
    PROG_IDLE,
    PROG_COPY,
    PROG_WAIT
  } spe_prog_state_t;

  typedef logic [7:0] spe_byte_t;

endpackage

// ### spe_sync.sv
`timescale 1ns/1ps
// Two-stage synchroniser; the first stage feeds only the second.
module spe_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk_i,              // Destination clock.
  input wire logic [WIDTH-1:0] d_i,    // Asynchronous input.
  output logic [WIDTH-1:0] q_o         // Synchronised output.
);
  logic [WIDTH-1:0] meta_reg;

  // No reset: the chain flushes within two clocks of any edge.
  always_ff @(posedge clk_i) begin
    meta_reg <= d_i;
    q_o <= meta_reg;
  end
endmodule

// ### spe_prot_check.sv
`timescale 1ns/1ps
// Decides whether an address lies in the block-guarded region.
module spe_prot_check #(
  parameter int ADDR_W = 11
) (
  input wire logic [1:0] guard_i,          // Block guard code {hi, lo}.
  input wire logic [ADDR_W-1:0] addr_i,    // Array address to check.
  output logic prot_o                      // High when read-only.
);
  // Quarter, half or full array from the top address downward.
  always_comb begin
    unique case (guard_i)
      2'b00: prot_o = 1'b0;
      2'b01: prot_o = &addr_i[ADDR_W-1:ADDR_W-2];
      2'b10: prot_o = addr_i[ADDR_W-1];
      2'b11: prot_o = 1'b1;
    endcase
  end
endmodule

// ### spe_eeprom_top.sv
`timescale 1ns/1ps
`include "spe_defines.svh"
// Serial EEPROM front end. The serial clock domain shifts bytes and
// drives the output; the system domain judges each frame when select
// rises and runs the self-timed programming cycle.
module spe_eeprom_top
  import spe_pkg::*;
#(
  parameter int ADDR_W = `SPE_ADDR_W,
  parameter int WRITE_CYCLES = `SPE_TWC_CYCLES
) (
  input wire logic clk_sys_i,          // System clock, 250 MHz.
  input wire logic reset_n_i,          // Synchronous reset, active low.
  input wire logic sck_i,              // Serial clock from the host.
  input wire logic cs_n_i,             // Chip select, active low.
  input wire logic si_i,               // Serial data in.
  input wire logic pause_input_n_i,    // Pause, active low.
  input wire logic write_guard_n_i,    // Write guard pin, active low.
  output logic so_o,                   // Serial data out.
  output logic so_oe_n_o               // Output enable, low drives.
);
  localparam int DEPTH = 1 << ADDR_W;
  localparam int PAGES_AW = `SPE_PAGE_AW;
  localparam int TW = $clog2(WRITE_CYCLES + 1);

  // Serial clock domain state.
  logic in_frame_reg;
  logic [2:0] bit_cnt_reg;
  logic [2:0] byte_cnt_reg;
  spe_byte_t rx_reg;
  spe_byte_t op_reg;
  spe_byte_t addr_hi_reg;
  spe_byte_t sr_data_reg;
  logic [ADDR_W-1:0] ptr_reg;
  spe_byte_t tx_reg;
  logic tx_on_reg;
  logic wr_go_reg;
  spe_byte_t page_buf [0:`SPE_PAGE_BYTES-1];
  logic [`SPE_PAGE_BYTES-1:0] mask_reg;
  spe_byte_t status_lk;

  // System domain state.
  spe_prog_state_t prog_state_reg;
  logic [TW-1:0] timer_reg;
  logic [PAGES_AW-1:0] copy_idx_reg;
  logic write_enable_latch_reg;
  logic guard_pin_enable_reg;
  logic [1:0] bp_reg;
  logic cs_prev_reg;
  logic saw_clk_reg;
  logic wp_trip_reg;
  spe_byte_t mem [0:DEPTH-1];
  logic cs_s;
  logic wp_n_s;
  logic inf_s;

  // Helper terms.
  logic first;
  logic active;
  logic [2:0] bpos;
  logic [2:0] bnum;
  logic byte_end;
  spe_byte_t rx_next;
  logic [ADDR_W-1:0] start_addr;
  logic [ADDR_W-1:0] rd_idx;
  spe_byte_t rd_data;
  logic busy;
  logic busy_lk;
  spe_byte_t status_word;
  logic frame_end;
  logic saw;
  logic whole;
  logic hw_guard;
  logic page_prot;
  logic set_latch;
  logic clr_latch;
  logic st_wr;
  logic ar_wr;
  logic prog_done;

  // ---------------- Serial clock domain ----------------

  // A bit is taken only while selected and not paused.
  assign first = ~in_frame_reg;
  assign active = ~cs_n_i & pause_input_n_i;
  assign bpos = first ? 3'h0 : bit_cnt_reg;
  assign bnum = first ? 3'h0 : byte_cnt_reg;
  assign byte_end = active & (bpos == 3'h7);
  assign rx_next = {rx_reg[6:0], si_i};
  // Only the significant address bits are kept.
  assign start_addr = ADDR_W'({addr_hi_reg, rx_next});
  assign busy_lk = status_lk[`SPE_SR_BUSY];

  // Frame marker, cleared by select itself since the serial clock
  // stands still between frames and cannot end the frame on its own.
  always_ff @(posedge sck_i or posedge cs_n_i) begin
    if (cs_n_i) begin
      in_frame_reg <= 1'b0;
    end else if (pause_input_n_i) begin
      in_frame_reg <= 1'b1;
    end
  end

  // Input shifter and bit/byte counters, sampled on the rising edge.
  always_ff @(posedge sck_i) begin
    if (active) begin
      rx_reg <= rx_next;
      bit_cnt_reg <= bpos + 3'h1;
      if (byte_end) begin
        byte_cnt_reg <= (bnum == 3'h7) ? 3'h7 : bnum + 3'h1;
      end else begin
        byte_cnt_reg <= bnum;
      end
    end
  end

  // Opcode, address and status data bytes.
  always_ff @(posedge sck_i) begin
    if (byte_end) begin
      if (bnum == 3'h0) begin
        op_reg <= rx_next;
      end
      if (bnum == 3'h1) begin
        addr_hi_reg <= rx_next;
        sr_data_reg <= rx_next;
      end
    end
  end

  // Page load gate, latched at the opcode while not busy so that a
  // rejected write can never disturb a page being programmed.
  always_ff @(posedge sck_i) begin
    if (byte_end && bnum == 3'h0) begin
      wr_go_reg <= (rx_next == `SPE_OP_WRITE) & ~busy_lk;
    end
  end

  // Page buffer: each data byte lands at the in-page address.
  always_ff @(posedge sck_i) begin
    if (byte_end && op_reg == `SPE_OP_WRITE && wr_go_reg && bnum >= 3'h3) begin
      page_buf[ptr_reg[PAGES_AW-1:0]] <= rx_next;
    end
  end

  // Loaded-byte mask, cleared when a new write opcode is accepted.
  always_ff @(posedge sck_i) begin
    if (byte_end && bnum == 3'h0 && rx_next == `SPE_OP_WRITE && !busy_lk) begin
      mask_reg <= '0;
    end else if (byte_end && op_reg == `SPE_OP_WRITE && wr_go_reg && bnum >= 3'h3) begin
      mask_reg[ptr_reg[PAGES_AW-1:0]] <= 1'b1;
    end
  end

  // Address pointer: reads roll over the whole array, writes only
  // within the page, keeping the page bits fixed.
  always_ff @(posedge sck_i) begin
    if (byte_end && bnum == 3'h2) begin
      ptr_reg <= (op_reg == `SPE_OP_READ) ? start_addr + 1'b1 : start_addr;
    end else if (byte_end && bnum >= 3'h3) begin
      if (op_reg == `SPE_OP_READ) begin
        ptr_reg <= ptr_reg + 1'b1;
      end else if (op_reg == `SPE_OP_WRITE) begin
        ptr_reg[PAGES_AW-1:0] <= ptr_reg[PAGES_AW-1:0] + 1'b1;
      end
    end
  end

  // Array read port; the array only changes while busy, when reads
  // are refused, so the link may look at it directly.
  assign rd_idx = (bnum == 3'h2) ? start_addr : ptr_reg;
  assign rd_data = mem[rd_idx];

  // Next byte to send, chosen at the rising edge ending each byte.
  always_ff @(posedge sck_i) begin
    if (active && first) begin
      tx_on_reg <= 1'b0;
    end
    if (byte_end) begin
      if (bnum == 3'h0 && rx_next == `SPE_OP_RD_SR) begin
        tx_reg <= status_lk;
        tx_on_reg <= 1'b1;
      end else if (bnum != 3'h0 && op_reg == `SPE_OP_RD_SR) begin
        tx_reg <= status_lk;
      end else if (bnum == 3'h2 && op_reg == `SPE_OP_READ && !busy_lk) begin
        tx_reg <= rd_data;
        tx_on_reg <= 1'b1;
      end else if (bnum >= 3'h3 && op_reg == `SPE_OP_READ) begin
        tx_reg <= rd_data;
      end
    end
  end

  // Output shifter on the falling edge; select high or a pause floats
  // the pin at once, without waiting for a clock that may not come.
  always_ff @(negedge sck_i or posedge cs_n_i or negedge pause_input_n_i) begin
    if (cs_n_i || !pause_input_n_i) begin
      so_oe_n_o <= 1'b1;
      so_o <= 1'b0;
    end else begin
      // Gated so that a floated pin never shows a stale data bit.
      so_o <= tx_reg[~bit_cnt_reg] & tx_on_reg & in_frame_reg;
      so_oe_n_o <= ~(tx_on_reg & in_frame_reg);
    end
  end

  // Status view for the link; several bits can change together, as latch and busy do when a write cycle ends.
  spe_sync #(
    .WIDTH(8)
  ) u_status_sync (
    .clk_i(sck_i),
    .d_i(status_word),
    .q_o(status_lk)
  );

  // ---------------- System clock domain ----------------

  spe_sync #(
    .WIDTH(3)
  ) u_sys_sync (
    .clk_i(clk_sys_i),
    .d_i({cs_n_i, write_guard_n_i, in_frame_reg}),
    .q_o({cs_s, wp_n_s, inf_s})
  );

  assign busy = (prog_state_reg != PROG_IDLE);
  // Upper bits 6..4 always read zero.
  assign status_word = {guard_pin_enable_reg, 3'b000, bp_reg, write_enable_latch_reg, busy};

  // Frame end is the rise of select; link registers are then frozen.
  assign frame_end = cs_s & ~cs_prev_reg;
  assign saw = saw_clk_reg | inf_s;
  assign whole = (bit_cnt_reg == 3'h0);
  assign hw_guard = guard_pin_enable_reg & (~wp_n_s | wp_trip_reg);

  spe_prot_check #(
    .ADDR_W(ADDR_W)
  ) u_prot (
    .guard_i(bp_reg),
    .addr_i({ptr_reg[ADDR_W-1:PAGES_AW], {PAGES_AW{1'b0}}}),
    .prot_o(page_prot)
  );

  // Frame verdicts; anything else, including undefined opcodes and
  // every command but a status read during a write cycle, is dropped silently.
  assign set_latch = frame_end & saw & whole & ~busy & (byte_cnt_reg == 3'h1)
                     & (op_reg == `SPE_OP_SET_LATCH);
  assign clr_latch = frame_end & saw & whole & ~busy & (byte_cnt_reg != 3'h0)
                     & (op_reg == `SPE_OP_CLR_LATCH);
  assign st_wr = frame_end & saw & whole & ~busy & (byte_cnt_reg >= 3'h2)
                 & (op_reg == `SPE_OP_WR_SR) & write_enable_latch_reg & ~hw_guard;
  assign ar_wr = frame_end & saw & whole & ~busy & (byte_cnt_reg >= 3'h4)
                 & (op_reg == `SPE_OP_WRITE) & write_enable_latch_reg & ~page_prot;
  assign prog_done = (prog_state_reg == PROG_WAIT) && (timer_reg == '0);

  // Frame tracking: select edge, clock seen, and guard pin dropping
  // while selected, which spoils a pending status write.
  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      cs_prev_reg <= 1'b1;
      saw_clk_reg <= 1'b0;
      wp_trip_reg <= 1'b0;
    end else begin
      cs_prev_reg <= cs_s;
      if (frame_end) begin
        saw_clk_reg <= 1'b0;
        wp_trip_reg <= 1'b0;
      end else begin
        saw_clk_reg <= saw_clk_reg | inf_s;
        wp_trip_reg <= wp_trip_reg | (~cs_s & ~wp_n_s);
      end
    end
  end

  // Write enable latch; a set at frame end cannot meet a completion
  // because no frame is accepted while busy.
  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      write_enable_latch_reg <= 1'b0;
    end else if (set_latch) begin
      write_enable_latch_reg <= 1'b1;
    end else if (clr_latch || prog_done) begin
      write_enable_latch_reg <= 1'b0;
    end
  end

  // Nonvolatile status bits; only 7, 3 and 2 are taken.
  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      guard_pin_enable_reg <= 1'(`SPE_NV_RESET >> `SPE_SR_GUARD_PIN_EN);
      bp_reg <= 2'(`SPE_NV_RESET >> `SPE_SR_BP_LO);
    end else if (st_wr) begin
      guard_pin_enable_reg <= sr_data_reg[`SPE_SR_GUARD_PIN_EN];
      bp_reg <= {sr_data_reg[`SPE_SR_BP_HI], sr_data_reg[`SPE_SR_BP_LO]};
    end
  end

  // Programming sequencer: copy the loaded page, then wait out the
  // rest of the write time before reporting ready.
  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      prog_state_reg <= PROG_IDLE;
      timer_reg <= '0;
      copy_idx_reg <= '0;
    end else begin
      unique case (prog_state_reg)
        PROG_IDLE: begin
          copy_idx_reg <= '0;
          timer_reg <= TW'(WRITE_CYCLES - 1);
          if (ar_wr) begin
            prog_state_reg <= PROG_COPY;
          end else if (st_wr) begin
            prog_state_reg <= PROG_WAIT;
          end
        end
        PROG_COPY: begin
          timer_reg <= timer_reg - 1'b1;
          copy_idx_reg <= copy_idx_reg + 1'b1;
          if (copy_idx_reg == PAGES_AW'(`SPE_PAGE_BYTES - 1)) begin
            prog_state_reg <= PROG_WAIT;
          end
        end
        PROG_WAIT: begin
          if (timer_reg == '0) begin
            prog_state_reg <= PROG_IDLE;
          end else begin
            timer_reg <= timer_reg - 1'b1;
          end
        end
      endcase
    end
  end

  // Array cells; no reset since their contents are nonvolatile.
  always_ff @(posedge clk_sys_i) begin
    if (prog_state_reg == PROG_COPY && mask_reg[copy_idx_reg]) begin
      mem[{ptr_reg[ADDR_W-1:PAGES_AW], copy_idx_reg}] <= page_buf[copy_idx_reg];
    end
  end

endmodule

// ### spe_eeprom_top_asserts.sv
`timescale 1ns/1ps
// Pin-level checks of the serial front end, seen from the system clock.
module spe_eeprom_top_chk (
  input wire logic clk_sys_i,        // System clock.
  input wire logic reset_n_i,        // Reset, active low.
  input wire logic sck_i,            // Serial clock.
  input wire logic cs_n_i,           // Select, active low.
  input wire logic si_i,             // Serial in.
  input wire logic pause_input_n_i,  // Pause, active low.
  input wire logic write_guard_n_i,  // Guard pin, active low.
  input wire logic so_o,             // Serial out.
  input wire logic so_oe_n_o         // Output enable, active low.
);
  logic [3:0] edge_cnt_reg;
  // Counts rising edges taken in a frame; it saturates so the opcode check stays cheap.
  always_ff @(posedge sck_i or posedge cs_n_i) begin
    if (cs_n_i) begin
      edge_cnt_reg <= 4'h0;
    end else if (pause_input_n_i && edge_cnt_reg != 4'h8) begin
      edge_cnt_reg <= edge_cnt_reg + 4'h1;
    end
  end
  sequence s_quiet;
    $stable(sck_i) && $stable(cs_n_i) && $stable(pause_input_n_i) && !cs_n_i;
  endsequence
  sequence s_on;
    $fell(so_oe_n_o);
  endsequence
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!reset_n_i);
  AST_CS_FLOAT: assert property (cs_n_i |-> so_oe_n_o)
    else $error("output driven while deselected");
  AST_PAUSE_FLOAT: assert property (!pause_input_n_i |-> so_oe_n_o)
    else $error("output driven while paused");
  AST_FLOAT_LOW: assert property (so_oe_n_o |-> !so_o)
    else $error("floated output not low");
  AST_SO_FALL: assert property (s_quiet |-> $stable(so_o))
    else $error("output moved without a falling edge");
  AST_OPCODE_FIRST: assert property (!so_oe_n_o |-> edge_cnt_reg == 4'h8)
    else $error("output before eight input bits");
  AST_ON_FALL: assert property (s_on |-> !sck_i && pause_input_n_i)
    else $error("output enabled off a falling edge");
  AST_STAYS_ON: assert property (!$past(so_oe_n_o) && !cs_n_i && pause_input_n_i |-> !so_oe_n_o)
    else $error("output dropped inside a frame");
  AST_OFF_CAUSE: assert property ($rose(so_oe_n_o) |-> cs_n_i || !pause_input_n_i)
    else $error("output floated without cause");
endmodule
bind spe_eeprom_top spe_eeprom_top_chk u_chk (.clk_sys_i, .reset_n_i, .sck_i, .cs_n_i, .si_i,
  .pause_input_n_i, .write_guard_n_i, .so_o, .so_oe_n_o);

// ### spe_host_model.sv
`timescale 1ns/1ps
// Host end of the link; the serial clock only runs inside frames.
module spe_host_model (
  input wire logic clk_sys_i,  // Aligns frame starts.
  input wire logic so_i,       // Device serial out.
  input wire logic so_oe_n_i,  // Device output enable, active low.
  output logic sck_o,          // Serial clock, 30 ns period.
  output logic cs_n_o,         // Chip select, active low.
  output logic si_o,           // Serial data to the device.
  output logic pause_n_o       // Pause, active low.
);
  logic mode3 = 1'b0;
  logic drove = 1'b0;
  // Idle levels; one early select rise clears the frame marker and output flops, which have no other reset.
  initial begin
    sck_o = 1'b0;
    cs_n_o = 1'b0;
    si_o = 1'b0;
    pause_n_o = 1'b1;
    #1;
    cs_n_o = 1'b1;
  end
  // Select falls with the clock already at its idle level for the mode.
  task automatic start();
    @(posedge clk_sys_i);
    #1;
    sck_o = mode3;
    drove = 1'b0;
    #15;
    cs_n_o = 1'b0;
    #15;
  endtask
  // Sends n bits MSB first; a floated output reads as a changing pattern.
  task automatic xfer(input logic [7:0] tx, input int n, input int pz, output logic [7:0] rx);
    rx = 8'h00;
    for (int i = 7; i > 7 - n; i--) begin
      sck_o = 1'b0;
      si_o = tx[i];
      if (i == pz) begin
        #5;
        pause_n_o = 1'b0;
        repeat (2) begin
          #10;
          si_o = ~tx[i];
          sck_o = 1'b1;
          #15;
          sck_o = 1'b0;
        end
        #10;
        si_o = tx[i];
        pause_n_o = 1'b1;
        #5;
      end
      #15;
      rx[i] = so_oe_n_i ? i[0] : so_i;
      drove = drove | ~so_oe_n_i;
      sck_o = 1'b1;
      #15;
    end
  endtask
  // Select rises at a clock idle level; the released data line is inverted.
  task automatic stop();
    sck_o = mode3;
    #15;
    cs_n_o = 1'b1;
    si_o = ~si_o;
    #40;
  endtask
endmodule

// ### tb.sv
`timescale 1ns/1ps
`include "spe_defines.svh"
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin err_total++; $display("mismatch at %0t: got %h exp %h", $time, (a), (e)); end end
module tb
  import spe_pkg::*;
;
  typedef struct packed {spe_byte_t op; spe_byte_t sr;} spe_row_t;
  logic clk_sys_i;
  logic reset_n_i = 1'b0;
  logic write_guard_n_i = 1'b1;
  logic sck_i, cs_n_i, si_i, pause_input_n_i, so_o, so_oe_n_o;
  int err_total = 0;
  int num_checks = 0;
  spe_byte_t mem [0:2047];
  spe_byte_t s;
  spe_byte_t d[$];
  spe_row_t rows [11] = '{'{8'h06, 8'h02}, '{8'h04, 8'h00}, '{8'h06, 8'h02}, '{8'hFF, 8'h02},
    '{8'h00, 8'h02}, '{8'h07, 8'h02}, '{8'h05, 8'h02}, '{8'h01, 8'h02}, '{8'h02, 8'h02},
    '{8'h03, 8'h02}, '{8'h04, 8'h00}};
  spe_host_model host (.clk_sys_i(clk_sys_i), .so_i(so_o), .so_oe_n_i(so_oe_n_o), .sck_o(sck_i),
    .cs_n_o(cs_n_i), .si_o(si_i), .pause_n_o(pause_input_n_i));
  // A short write cycle keeps busy visible across one status read.
  spe_eeprom_top #(.ADDR_W(11), .WRITE_CYCLES(400)) uut (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i),
    .sck_i(sck_i), .cs_n_i(cs_n_i), .si_i(si_i), .pause_input_n_i(pause_input_n_i),
    .write_guard_n_i(write_guard_n_i), .so_o(so_o), .so_oe_n_o(so_oe_n_o));
  // System clock, 4 ns period.
  initial begin
    clk_sys_i = 1'b0;
    forever #2 clk_sys_i = ~clk_sys_i;
  end
  task automatic rst();
    @(posedge clk_sys_i);
    #1;
    reset_n_i = 1'b0;
    repeat (5) @(posedge clk_sys_i);
    #1;
    reset_n_i = 1'b1;
    repeat (4) @(posedge clk_sys_i);
  endtask
  task automatic op(input spe_byte_t q[$], input int last_n = 8, input int pz = -1);
    spe_byte_t r;
    host.start();
    foreach (q[k]) host.xfer(q[k], (k == q.size() - 1) ? last_n : 8, (k == q.size() - 1) ? pz : -1, r);
    host.stop();
  endtask
  task automatic status_read_cmd(output spe_byte_t v);
    spe_byte_t r;
    host.start();
    host.xfer(`SPE_OP_RD_SR, 8, -1, r);
    host.xfer(8'h00, 8, -1, v);
    host.stop();
  endtask
  // Polls until busy clears, with a bounded number of polls.
  task automatic idle(input spe_byte_t e);
    spe_byte_t v;
    int n;
    n = 0;
    do begin
      status_read_cmd(v);
      n++;
    end while (v[0] !== 1'b0 && n < 50);
    `CHK(v, e)
  endtask
  task automatic wr(input logic [15:0] a, input spe_byte_t q[$], input logic ok, input int pz = -1);
    spe_byte_t f[$];
    op({`SPE_OP_SET_LATCH});
    f = {`SPE_OP_WRITE, a[15:8], a[7:0]};
    foreach (q[k]) begin
      f.push_back(q[k]);
      if (ok) mem[{a[10:5], 5'(a[4:0] + k)}] = q[k];
    end
    op(f, 8, pz);
  endtask
  task automatic wsr(input spe_byte_t v);
    op({`SPE_OP_SET_LATCH});
    op({`SPE_OP_WR_SR, v});
  endtask
  // Reads n bytes; while busy the device must stay floated instead.
  task automatic rd(input logic [15:0] a, input int n, input logic live);
    spe_byte_t r;
    host.start();
    host.xfer(`SPE_OP_READ, 8, -1, r);
    host.xfer(a[15:8], 8, -1, r);
    host.xfer(a[7:0], 8, -1, r);
    for (int k = 0; k < n; k++) begin
      host.xfer(8'h00, 8, -1, r);
      if (live) `CHK(r, mem[11'(a + k)])
    end
    host.stop();
    if (!live) `CHK(host.drove, 1'b0)
  endtask
  task automatic give_verdict();
    if (err_total == 0 && num_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // Watchdog well beyond the expected run of about 56 us.
  initial begin
    #150000;
    err_total++;
    give_verdict();
  end
  initial begin
    rst();
    status_read_cmd(s);
    `CHK(s, 8'h00)
    foreach (rows[i]) begin
      host.mode3 = i[0];
      op({rows[i].op});
      `CHK(host.drove, 1'b0)
      status_read_cmd(s);
      `CHK(s, rows[i].sr)
    end
    host.mode3 = 1'b0;
    // The latch is set only by a whole single-byte frame.
    op({8'h06, 8'h00});
    status_read_cmd(s);
    `CHK(s[1], 1'b0)
    op({8'h06}, 4);
    status_read_cmd(s);
    `CHK(s[1], 1'b0)
    wr(16'h0000, {8'h5A}, 1'b1);
    status_read_cmd(s);
    `CHK(s, 8'h03)
    idle(8'h00);
    op({8'h02, 8'h00, 8'h00, 8'hA5});
    status_read_cmd(s);
    `CHK(s[0], 1'b0)
    // Page load past the page end, with upper address bits set.
    for (int k = 0; k < 34; k++) d.push_back(spe_byte_t'(8'h10 + k));
    wr(16'hF7E5, d, 1'b1);
    op({8'h06});
    rd(16'h07E0, 1, 1'b0);
    idle(8'h00);
    // Only written cells are compared, through the wrap to address zero.
    rd(16'h07E5, 28, 1'b1);
    wsr(8'hFF);
    idle(8'h8C);
    wr(16'h0000, {8'h77}, 1'b0);
    status_read_cmd(s);
    `CHK(s[0], 1'b0)
    @(posedge clk_sys_i);
    #1;
    write_guard_n_i = 1'b0;
    wsr(8'h00);
    status_read_cmd(s);
    `CHK(s & 8'hFD, 8'h8C)
    @(posedge clk_sys_i);
    #1;
    write_guard_n_i = 1'b1;
    wsr(8'h04);
    idle(8'h04);
    wr(16'h05FF, {8'h33}, 1'b1, 3);
    status_read_cmd(s);
    `CHK(s[0], 1'b1)
    idle(8'h04);
    wr(16'h0600, {8'h44}, 1'b0);
    status_read_cmd(s);
    `CHK(s[0], 1'b0)
    op({8'h02, 8'h00, 8'h00, 8'h99}, 4);
    status_read_cmd(s);
    `CHK(s[0], 1'b0)
    rd(16'h05FF, 1, 1'b1);
    rd(16'h0000, 1, 1'b1);
    op({8'h06});
    rst();
    status_read_cmd(s);
    `CHK(s, 8'h00)
    give_verdict();
  end
endmodule
